// File: rtc_sf_pkg.sv
// Purpose: Shared constants and types for the real-time clock status flags.
// Assumes: APB register bus with 32-bit data, pclk at 25 MHz.
// Notes:   Offsets, bit positions and the prdata, flag, irq status and mask reset values live here.
`default_nettype none
package rtc_sf_pkg;

   // Register byte offsets.
   localparam logic [11:0] OFF_STATUS   = 12'h000;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h004;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h008;

   // Status word bit positions.
   localparam int BIT_HALF_SECOND  = 0;
   localparam int BIT_ALARM_UPDATE = 1;
   localparam int BIT_TIME_SYNC    = 2;
   localparam int BIT_ALARM_EVENT  = 5;

   // Interrupt status and mask bit positions.
   localparam int IRQ_BIT_ALARM  = 0;
   localparam int IRQ_BIT_SECOND = 1;
   localparam int IRQ_W          = 2;

   // Values after reset.
   localparam logic [31:0]      RST_PRDATA   = 32'h0000_0000;
   localparam logic [IRQ_W-1:0] RST_IRQ_STAT = 2'h0;
   localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 2'h0;

   // Timing.
   localparam longint CLK_PERIOD_NS  = 40;
   localparam longint ONE_SECOND_NS  = 1000000000;
   localparam longint SYNC_WINDOW_NS = 1000;
   localparam longint ONE_SECOND_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;
   localparam longint SYNC_WINDOW_CYCLES =
      (SYNC_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // The four hardware-owned flags.
   typedef struct packed {
      logic alarm_event_flag;
      logic time_sync;
      logic alarm_update_pending;
      logic half_second_phase;
   } rtc_sf_flags_s;

   localparam rtc_sf_flags_s RST_FLAGS = 4'h0;

endpackage : rtc_sf_pkg
`default_nettype wire

// File: rtc_sf_timebase.sv
// Purpose: One-second timebase giving the half-second phase and sync window.
// Assumes: Single clock; counts are shortened for simulation by parameter.
// Notes:   All outputs are registered.
`timescale 1ns/1ns
`default_nettype none
module rtc_sf_timebase #(
   parameter int CNT_W      = 32,
   parameter int SEC_CYCLES = int'(rtc_sf_pkg::ONE_SECOND_CYCLES),
   parameter int WIN_CYCLES = int'(rtc_sf_pkg::SYNC_WINDOW_CYCLES)
) (
   input  wire logic pclk,
   input  wire logic presetn,
   output var  logic half_second,
   output var  logic sync_window,
   output var  logic second_tick
);

   localparam logic [CNT_W-1:0] LAST   = CNT_W'(SEC_CYCLES - 1);
   localparam logic [CNT_W-1:0] HALF   = CNT_W'(SEC_CYCLES / 2);
   localparam logic [CNT_W-1:0] WIN_AT = CNT_W'(SEC_CYCLES - WIN_CYCLES);

   logic [CNT_W-1:0] count;
   wire              wrap       = (count == LAST);
   wire  [CNT_W-1:0] next_count = wrap ? '0 : count + CNT_W'(1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count       <= '0;
         half_second <= 1'b0;
         sync_window <= 1'b0;
         second_tick <= 1'b0;
      end else begin
         count       <= next_count;
         // Second half of each second once the counter passes midpoint.
         half_second <= (next_count >= HALF);
         // Time fields roll over at the wrap, so flag the run-up to it.
         sync_window <= (next_count >= WIN_AT);
         second_tick <= wrap;
      end
   end

endmodule // rtc_sf_timebase
`default_nettype wire

// File: rtc_sf_top.sv
// Purpose: Read-only status flags of a clock and calendar unit, over APB.
// Assumes: alarm_match and alarm_busy come from logic on pclk.
// Notes:   Zero-wait APB slave; unmapped addresses answer with pslverr.
//
// Functional notes
// - Alarm event flag sets on an alarm match and holds until the next second boundary.
// - Only hardware sets and clears the four flags; all reset to zero.
// - Time-sync flag is high whenever time fields may change under a read.
// - Alarm-update flag high means alarm and control must not be written.
// - Alarm enable and repeat count instability is shown by that flag.
// - Half-second flag is one in the second half of each second.
// - Status bits 31 to 6 and 4 to 3 always read zero.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module rtc_sf_top #(
   parameter int SEC_CYCLES = int'(rtc_sf_pkg::ONE_SECOND_CYCLES)
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic        alarm_match,
   input  wire logic        alarm_busy,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   output var  logic        irq,
   output var  logic [3:0]  flags_out
);

   logic half_second;
   logic sync_window;
   logic second_tick;

   rtc_sf_timebase #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_timebase (
      .pclk        (pclk),
      .presetn     (presetn),
      .half_second (half_second),
      .sync_window (sync_window),
      .second_tick (second_tick)
   );

   rtc_sf_pkg::rtc_sf_flags_s           flags;
   rtc_sf_pkg::rtc_sf_flags_s           next_flags;
   logic [rtc_sf_pkg::IRQ_W-1:0]        irq_stat;
   logic [rtc_sf_pkg::IRQ_W-1:0]        irq_mask;

   // Flag logic. The alarm flag holds for the second of the match and is
   // dropped by hardware at the next second boundary; a match wins.
   wire alarm_next = alarm_match |
                     (flags.alarm_event_flag & ~second_tick);

   // Alarm comparison also runs at the rollover, so alarm enable and
   // repeat count may move then as well as while the core is busy.
   wire alarm_pend = alarm_busy | sync_window;

   always_comb begin
      next_flags                      = flags;
      next_flags.alarm_event_flag     = alarm_next;
      next_flags.time_sync            = sync_window;
      next_flags.alarm_update_pending = alarm_pend;
      next_flags.half_second_phase    = half_second;
   end

   // APB decode.
   wire setup      = psel & ~penable;
   wire access     = psel & penable & pready;
   wire hit_status = (paddr == rtc_sf_pkg::OFF_STATUS);
   wire hit_istat  = (paddr == rtc_sf_pkg::OFF_IRQ_STAT);
   wire hit_imask  = (paddr == rtc_sf_pkg::OFF_IRQ_MASK);
   wire hit_any    = hit_status | hit_istat | hit_imask;

   // Status word: unimplemented bits are forced to zero.
   wire [31:0] status_word = {
      26'h0,
      flags.alarm_event_flag,
      2'h0,
      flags.time_sync,
      flags.alarm_update_pending,
      flags.half_second_phase
   };

   wire [31:0] rd_mux = hit_status ? status_word :
                        hit_istat  ? {30'h0, irq_stat} :
                        hit_imask  ? {30'h0, irq_mask} :
                                     32'h0000_0000;

   // Only the mask takes writes; a write to the status word is dropped.
   wire mask_wr    = access & pwrite & hit_imask;
   wire istat_rdcl = access & ~pwrite & hit_istat;

   wire [rtc_sf_pkg::IRQ_W-1:0] irq_events = {second_tick, alarm_match};
   // Only the bits that the read returned are cleared, so an event that
   // lands between setup and access is not lost; set beats clear.
   wire [rtc_sf_pkg::IRQ_W-1:0] next_irq_stat =
      (istat_rdcl ? (irq_stat & ~prdata[rtc_sf_pkg::IRQ_W-1:0]) :
                    irq_stat) | irq_events;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= rtc_sf_pkg::RST_FLAGS;
      end else begin
         flags <= next_flags;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= rtc_sf_pkg::RST_IRQ_STAT;
         irq_mask <= rtc_sf_pkg::RST_IRQ_MASK;
         irq      <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         if (mask_wr) begin
            irq_mask <= pwdata[rtc_sf_pkg::IRQ_W-1:0];
         end
         irq <= |(irq_stat & irq_mask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= rtc_sf_pkg::RST_PRDATA;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~hit_any;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_out <= 4'h0;
      end else begin
         flags_out <= next_flags;
      end
   end

endmodule // rtc_sf_top
`default_nettype wire

// File: rtc_sf_checker_assertions.sv
// Purpose: Timing checks on the status flags at the top ports.
// Assumes: One clock, pclk; presetn is active low.
// Notes:   Level lengths are checked at falls, clear of reset history.
`timescale 1ns/1ns
`default_nettype none
module rtc_sf_checker #(
   parameter int SEC_CYCLES = 100
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic        alarm_match,
   input wire logic        alarm_busy,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic [3:0]  flags_out
);
   localparam int HALF = SEC_CYCLES / 2;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   evt_set_a: assert property (alarm_match |=> flags_out[3])
      else $error("match not flagged");
   evt_cause_a: assert property ($rose(flags_out[3]) |->
      $past(alarm_match)) else $error("event flag without match");
   busy_pend_a: assert property (alarm_busy |=> flags_out[1])
      else $error("busy not flagged");
   stat_word_a: assert property (pready && !pwrite &&
      paddr == 12'h000 |-> prdata == {26'h0, $past(flags_out[3]), 2'h0,
      $past(flags_out[2:0])}) else $error("status word wrong");
   half_len_a: assert property ($fell(flags_out[0]) |->
      $past(flags_out[0], HALF) && !$past(flags_out[0], HALF + 1))
      else $error("half second length wrong");
   sync_len_a: assert property ($fell(flags_out[2]) |->
      $past(flags_out[2], 25) && !$past(flags_out[2], 26))
      else $error("sync window length wrong");
   sync_late_a: assert property (flags_out[2] |-> flags_out[0])
      else $error("sync outside second half");
   cover property (alarm_match);
   cover property ($fell(flags_out[2]));
   cover property (pready && paddr == 12'h000);
endmodule // rtc_sf_checker
bind rtc_sf_top rtc_sf_checker #(
   .SEC_CYCLES (SEC_CYCLES)
) u_chk (
   .pclk        (pclk),
   .presetn     (presetn),
   .psel        (psel),
   .penable     (penable),
   .pwrite      (pwrite),
   .paddr       (paddr),
   .alarm_match (alarm_match),
   .alarm_busy  (alarm_busy),
   .prdata      (prdata),
   .pready      (pready),
   .flags_out   (flags_out)
);
`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench for the status flags over APB.
// Assumes: A second is shortened to 100 cycles.
// Notes:   Each read takes three cycles, coprime to the second.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        alarm_match = 1'b0;
   logic        alarm_busy = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, irq, er;
   logic [3:0]  flags_out;
   int          failures = 0;
   int          checks = 0;
   int          n1, n2;
   always #20 pclk = ~pclk;
   rtc_sf_top #(
      .SEC_CYCLES (100)
   ) u_dut (
      .pclk        (pclk),
      .presetn     (presetn),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .pwdata      (pwdata),
      .alarm_match (alarm_match),
      .alarm_busy  (alarm_busy),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .irq         (irq),
      .flags_out   (flags_out)
   );
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask
   function automatic logic [31:0] mexp(input logic [31:0] d);
      return {30'h0, d[1:0]};
   endfunction
   // Waits for the end of a sync window, the start of a second.
   task automatic wait_sec;
      repeat (200) if (flags_out[2] !== 1'b1) @(posedge pclk);
      repeat (30) if (flags_out[2] === 1'b1) @(posedge pclk);
   endtask
   task automatic pulse;
      @(posedge pclk);
      alarm_match <= 1'b1;
      @(posedge pclk);
      alarm_match <= 1'b0;
   endtask
   task automatic results;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #400000;
      failures++;
      results();
   end
   initial begin
      void'($urandom(32'h81744ebf));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         chk(rd, 32'h0);
         chk(32'(er), 32'h0);
      end
      apb(1'b1, 12'h000, $urandom);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd & 32'hffff_fff8, 32'h0);
      repeat (4) begin
         n1 = $urandom;
         apb(1'b1, 12'h008, n1);
         apb(1'b0, 12'h008, 32'h0);
         chk(rd, mexp(n1));
         apb(1'b0, {10'($urandom_range(1023, 3)), 2'b00}, 32'h0);
         chk(rd, 32'h0);
         chk(32'(er), 32'h1);
      end
      $display("test registers done");
      apb(1'b1, 12'h008, 32'h1);
      wait_sec();
      pulse();
      apb(1'b0, 12'h000, 32'h0);
      chk(32'(rd[5]), 32'h1);
      chk(32'(irq), 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      chk(32'(rd[0]), 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      chk(32'(irq), 32'h0);
      apb(1'b1, 12'h008, 32'h0);
      pulse();
      repeat (3) @(posedge pclk);
      chk(32'(irq), 32'h0);
      wait_sec();
      apb(1'b0, 12'h000, 32'h0);
      chk(32'(rd[5]), 32'h0);
      alarm_busy <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(32'(rd[1]), 32'h1);
      alarm_busy <= 1'b0;
      $display("test alarm done");
      n1 = 0;
      n2 = 0;
      repeat (300) begin
         apb(1'b0, 12'h000, 32'h0);
         n1 += rd[0];
         n2 += rd[2];
      end
      chk(n1, 150);
      chk(n2, 75);
      $display("test phase done");
      apb(1'b1, 12'h008, 32'h2);
      wait_sec();
      apb(1'b0, 12'h004, 32'h0);
      chk(32'(rd[1]), 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      chk(32'(rd[1]), 32'h0);
      chk(32'(irq), 32'h0);
      wait_sec();
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h1);
      $display("test tick done");
      results();
   end
endmodule // tb_top
`default_nettype wire
